// *** logic/prgc_pkg.sv ***
`default_nettype none
package prgc_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int PIX_W = 16;
    localparam int COEF_W = 16;
    localparam int PROD_W = 32;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = 16;

    // gain is coefficient / 16384, so the product is shifted down by 14
    localparam int GAIN_SHIFT = 14;

    // ****************************************************************
    // register indices (byte address = 4 * index)
    // ****************************************************************
    localparam logic [IDX_W-1:0] IDX_OFFS_HI = 10'h03e;
    localparam logic [IDX_W-1:0] IDX_OFFS_LO = 10'h03f;
    localparam logic [IDX_W-1:0] IDX_GAIN_HI = 10'h040;
    localparam logic [IDX_W-1:0] IDX_GAIN_LO = 10'h041;
    localparam logic [IDX_W-1:0] IDX_SRC_SEL = 10'h042;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h043;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_OFFS_HI = 8'h00;
    localparam logic [7:0] RST_OFFS_LO = 8'h00;
    localparam logic [7:0] RST_GAIN_HI = 8'h40;
    localparam logic [7:0] RST_GAIN_LO = 8'h00;
    localparam logic [7:0] RST_SRC_SEL = 8'h01;

    // ****************************************************************
    // source select fields
    // ****************************************************************
    localparam int SEL_MUL_LSB = 0;
    localparam int SEL_OFFS_BIT = 2;
    localparam logic [7:0] SEL_RW_MASK = 8'h07;

    // ****************************************************************
    // status fields
    // ****************************************************************
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_FULL_BIT = 2;
    localparam int ST_LEVEL_LSB = 3;

    // multiplier source, in register order 0, 1, 2
    typedef enum logic [1:0] {
        MUL_BYPASS,
        MUL_FIXED,
        MUL_DRAM
    } prgc_mul_src_e;

    // per-pixel coefficient pair from the dram buffer
    typedef struct packed {
        logic [COEF_W-1:0] offset;
        logic [COEF_W-1:0] gain;
    } prgc_coef_s;

endpackage
`default_nettype wire

// *** logic/prgc_top.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// output fifo
// ********************************************************************
module prgc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } prgc_fifo_state_s;

    prgc_fifo_state_s st_ff;
    prgc_fifo_state_s nxt_st;
    logic do_wr;
    logic do_rd;

    // honest full and empty flags
    assign in_ready = (st_ff.count != CW'(DEPTH));
    assign out_valid = (st_ff.count != '0);
    assign out_data = st_ff.mem[st_ff.rd_ptr];
    assign level = st_ff.count;
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // pointer and count update
    always_comb
    begin
        nxt_st = st_ff;
        if (do_wr)
        begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr = (st_ff.wr_ptr == PW'(DEPTH-1)) ? '0 : st_ff.wr_ptr + 1'b1;
        end
        if (do_rd)
        begin
            nxt_st.rd_ptr = (st_ff.rd_ptr == PW'(DEPTH-1)) ? '0 : st_ff.rd_ptr + 1'b1;
        end
        if (do_wr && !do_rd)
        begin
            nxt_st.count = st_ff.count + 1'b1;
        end
        else if (do_rd && !do_wr)
        begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule

// ********************************************************************
// offset and gain correction stage
// ********************************************************************
module prgc_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prgc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pix_in_valid,
    output logic pix_in_ready,
    input wire logic [prgc_pkg::PIX_W-1:0] pix_in_data,
    input wire logic coef_valid,
    output logic coef_ready,
    input wire prgc_pkg::prgc_coef_s coef_data,
    output logic pix_out_valid,
    input wire logic pix_out_ready,
    output logic [prgc_pkg::PIX_W-1:0] pix_out_data
);

    localparam int LW = $clog2(prgc_pkg::FIFO_DEPTH+1);

    typedef struct packed {
        logic [7:0] offs_hi;
        logic [7:0] offs_lo;
        logic [7:0] gain_hi;
        logic [7:0] gain_lo;
        logic [7:0] src_sel;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic stg_valid;
        logic [prgc_pkg::PIX_W-1:0] stg_data;
    } prgc_state_s;

    prgc_state_s st_ff;
    prgc_state_s nxt_st;

    logic fifo_in_ready;
    logic [LW-1:0] fifo_level;
    logic [prgc_pkg::FIFO_W-1:0] fifo_out_data;
    logic fifo_out_valid;

    prgc_pkg::prgc_mul_src_e mul_src;
    logic offs_dram;
    logic need_coef;
    logic have_coef;
    logic stage_free;
    logic accept;
    logic [prgc_pkg::COEF_W-1:0] fix_offs;
    logic [prgc_pkg::COEF_W-1:0] fix_gain;
    logic [prgc_pkg::COEF_W-1:0] sel_offs;
    logic [prgc_pkg::COEF_W-1:0] sel_gain;
    logic [prgc_pkg::PIX_W:0] diff;
    logic [prgc_pkg::PIX_W-1:0] diff_clamped;
    logic [prgc_pkg::PROD_W-1:0] product;
    logic [prgc_pkg::PIX_W-1:0] result;
    logic setup;
    logic access;
    logic [31:0] status_word;

    // word index match for a register
    function automatic logic reg_hit(
        input logic [prgc_pkg::ADDR_W-1:0] addr,
        input logic [prgc_pkg::IDX_W-1:0] idx
    );
        reg_hit = (addr[prgc_pkg::ADDR_W-1:2] == idx);
    endfunction

    // ****************************************************************
    // coefficient selection
    // ****************************************************************

    // fixed coefficients from the byte pairs
    assign fix_offs = {st_ff.offs_hi, st_ff.offs_lo};
    assign fix_gain = {st_ff.gain_hi, st_ff.gain_lo};

    // source decode; code 3 acts as bypass
    assign mul_src = prgc_pkg::prgc_mul_src_e'(st_ff.src_sel[prgc_pkg::SEL_MUL_LSB +: 2]);
    assign offs_dram = st_ff.src_sel[prgc_pkg::SEL_OFFS_BIT];
    assign need_coef = offs_dram || (mul_src == prgc_pkg::MUL_DRAM);

    // offset source choice
    assign sel_offs = offs_dram ? coef_data.offset : fix_offs;

    // multiplier source choice
    assign sel_gain = (mul_src == prgc_pkg::MUL_DRAM) ? coef_data.gain : fix_gain;

    // ****************************************************************
    // arithmetic
    // ****************************************************************

    // offset removal with floor at zero
    always_comb
    begin
        diff = {1'b0, pix_in_data} - {1'b0, sel_offs};
        diff_clamped = diff[prgc_pkg::PIX_W] ? '0 : diff[prgc_pkg::PIX_W-1:0];
    end

    // gain multiply, scale and saturate
    always_comb
    begin
        product = diff_clamped * sel_gain;
        case (mul_src)
            prgc_pkg::MUL_FIXED,
            prgc_pkg::MUL_DRAM:
            begin
                // scale down by 16384 and saturate above full scale
                if (product[prgc_pkg::PROD_W-1:prgc_pkg::GAIN_SHIFT+prgc_pkg::PIX_W] != '0)
                begin
                    result = '1;
                end
                else
                begin
                    result = product[prgc_pkg::GAIN_SHIFT +: prgc_pkg::PIX_W];
                end
            end
            default:
            begin
                result = diff_clamped;
            end
        endcase
    end

    // ****************************************************************
    // stream handshake
    // ****************************************************************

    // a pixel waits for its coefficient only when dram supplies one
    assign have_coef = !need_coef || coef_valid;
    assign stage_free = !st_ff.stg_valid || fifo_in_ready;
    assign accept = pix_in_valid && have_coef && stage_free;
    assign pix_in_ready = have_coef && stage_free;
    assign coef_ready = need_coef && pix_in_valid && stage_free;

    // ****************************************************************
    // apb slave
    // ****************************************************************
    assign setup = psel && !penable;
    assign access = psel && penable && st_ff.ready;
    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.slverr;

    // status word: fifo level, full, empty and stage busy
    always_comb
    begin
        status_word = '0;
        status_word[prgc_pkg::ST_BUSY_BIT] = st_ff.stg_valid;
        status_word[prgc_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
        status_word[prgc_pkg::ST_FULL_BIT] = !fifo_in_ready;
        status_word[prgc_pkg::ST_LEVEL_LSB +: LW] = fifo_level;
    end

    // next state: bus answer, register writes, pipeline stage
    always_comb
    begin
        nxt_st = st_ff;
        // read data and error prepared in the setup cycle
        if (setup)
        begin
            nxt_st.ready = 1'b1;
            nxt_st.slverr = 1'b0;
            nxt_st.rdata = '0;
            if (reg_hit(paddr, prgc_pkg::IDX_OFFS_HI))
            begin
                nxt_st.rdata[7:0] = st_ff.offs_hi;
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_OFFS_LO))
            begin
                nxt_st.rdata[7:0] = st_ff.offs_lo;
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_GAIN_HI))
            begin
                nxt_st.rdata[7:0] = st_ff.gain_hi;
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_GAIN_LO))
            begin
                nxt_st.rdata[7:0] = st_ff.gain_lo;
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_SRC_SEL))
            begin
                nxt_st.rdata[7:0] = st_ff.src_sel;
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_STATUS))
            begin
                nxt_st.rdata = pwrite ? '0 : status_word;
            end
            else
            begin
                nxt_st.slverr = 1'b1;
            end
        end
        else if (access)
        begin
            nxt_st.ready = 1'b0;
            nxt_st.slverr = 1'b0;
        end
        // writes land at the completing edge only
        if (access && pwrite)
        begin
            if (reg_hit(paddr, prgc_pkg::IDX_OFFS_HI))
            begin
                nxt_st.offs_hi = pwdata[7:0];
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_OFFS_LO))
            begin
                nxt_st.offs_lo = pwdata[7:0];
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_GAIN_HI))
            begin
                nxt_st.gain_hi = pwdata[7:0];
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_GAIN_LO))
            begin
                nxt_st.gain_lo = pwdata[7:0];
            end
            else if (reg_hit(paddr, prgc_pkg::IDX_SRC_SEL))
            begin
                nxt_st.src_sel = pwdata[7:0] & prgc_pkg::SEL_RW_MASK;
            end
        end
        // output stage drains into the fifo, then refills
        if (st_ff.stg_valid && fifo_in_ready)
        begin
            nxt_st.stg_valid = 1'b0;
        end
        if (accept)
        begin
            nxt_st.stg_valid = 1'b1;
            nxt_st.stg_data = result;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.offs_hi <= prgc_pkg::RST_OFFS_HI;
            st_ff.offs_lo <= prgc_pkg::RST_OFFS_LO;
            st_ff.gain_hi <= prgc_pkg::RST_GAIN_HI;
            st_ff.gain_lo <= prgc_pkg::RST_GAIN_LO;
            st_ff.src_sel <= prgc_pkg::RST_SRC_SEL;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // output buffer
    // ****************************************************************
    prgc_fifo #(
        .WIDTH(prgc_pkg::FIFO_W),
        .DEPTH(prgc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(st_ff.stg_valid),
        .in_ready(fifo_in_ready),
        .in_data(st_ff.stg_data),
        .out_valid(fifo_out_valid),
        .out_ready(pix_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    assign pix_out_valid = fifo_out_valid;
    assign pix_out_data = fifo_out_data;

endmodule
`default_nettype wire

// *** tb/prgc_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********************
// upstream pixel and coefficient source
// ********************
module prgc_src (
    input wire logic clk,
    output logic pix_in_valid,
    input wire logic pix_in_ready,
    output logic [15:0] pix_in_data,
    output logic coef_valid,
    output prgc_pkg::prgc_coef_s coef_data
);
    typedef struct packed {
        logic [15:0] pix;
        prgc_pkg::prgc_coef_s c;
        logic [3:0] gap;
    } prgc_item_s;
    prgc_item_s q[$];
    prgc_item_s it;
    int n;

    // queue one pixel with its coefficient pair and a lead gap
    task push(input logic [15:0] p, input prgc_pkg::prgc_coef_s c, input logic [3:0] g);
        q.push_back('{p, c, g});
    endtask

    // idle lines toggle so stale data never looks valid
    initial
    begin
        pix_in_valid = 1'b0;
        coef_valid = 1'b0;
        pix_in_data = 16'h0;
        coef_data = 32'h0;
        forever
        begin
            if (q.size() == 0 || q[0].gap != 4'h0)
            begin
                pix_in_valid <= 1'b0;
                coef_valid <= 1'b0;
                pix_in_data <= ~pix_in_data;
                coef_data <= ~coef_data;
                @(posedge clk);
                if (q.size() != 0)
                    q[0].gap = q[0].gap - 4'h1;
            end
            else
            begin
                it = q.pop_front();
                pix_in_valid <= 1'b1;
                coef_valid <= 1'b1;
                pix_in_data <= it.pix;
                coef_data <= it.c;
                n = 0;
                do
                begin
                    @(posedge clk);
                    n++;
                end
                while (!pix_in_ready && n < 5000);
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/prgc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********************
// port checks
// ********************
module prgc_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pix_in_valid,
    input wire logic pix_in_ready,
    input wire logic coef_ready,
    input wire logic pix_out_valid,
    input wire logic pix_out_ready,
    input wire logic [prgc_pkg::PIX_W-1:0] pix_out_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_ans;
        psel && !penable |=> pready;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_rd;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("upper read bits set");
    property p_pair;
        coef_ready |-> pix_in_valid && pix_in_ready;
    endproperty
    a_pair: assert property (p_pair) else $error("coef taken alone");
    property p_lat;
        pix_in_valid && pix_in_ready && !pix_out_valid |-> ##2 pix_out_valid;
    endproperty
    a_lat: assert property (p_lat) else $error("result late");
    property p_hold;
        pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved");
endmodule

bind prgc_top prgc_properties i_props (.clk, .reset_n, .psel, .penable, .prdata, .pready,
    .pslverr, .pix_in_valid, .pix_in_ready, .coef_ready, .pix_out_valid, .pix_out_ready,
    .pix_out_data);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********************
// bench
// ********************
module tb_top;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, stall, osel, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, seed;
    logic pix_in_valid, pix_in_ready, coef_valid, coef_ready, pix_out_valid, pix_out_ready;
    logic [15:0] pix_in_data, pix_out_data, foff, fgain;
    logic [1:0] msel;
    prgc_pkg::prgc_coef_s coef_data;
    logic [15:0] exp_q[$];
    int err_total, total_checks, n;

    prgc_top i_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pix_in_valid, .pix_in_ready, .pix_in_data, .coef_valid,
        .coef_ready, .coef_data, .pix_out_valid, .pix_out_ready, .pix_out_data);
    prgc_src i_src (.clk, .pix_in_valid, .pix_in_ready, .pix_in_data, .coef_valid,
        .coef_data);

    // clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task print_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one apb transfer, then an idle cycle
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_total++;
            print_verdict();
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rdc(input logic [9:0] idx, input logic [7:0] e, input logic ee);
        apb(1'b0, idx, 8'h0);
        chk(r, {24'h0, e});
        chk({31'h0, er}, {31'h0, ee});
    endtask

    // expected pixel from the current settings
    function logic [15:0] model(input logic [15:0] p, input prgc_pkg::prgc_coef_s c);
        logic [15:0] o, g, d;
        logic [31:0] pr;
        o = osel ? c.offset : foff;
        g = (msel == 2'd2) ? c.gain : fgain;
        d = (p > o) ? p - o : 16'h0;
        pr = d * g;
        if (msel == 2'd0 || msel == 2'd3)
            return d;
        return (pr[31:30] != 2'h0) ? 16'hffff : pr[29:14];
    endfunction

    task send(input int k, input logic [3:0] gm);
        prgc_pkg::prgc_coef_s c;
        repeat (k)
        begin
            c = rnd() & 32'h0fffffff;
            r = rnd();
            exp_q.push_back(model(r[15:0], c));
            i_src.push(r[15:0], c, r[19:16] & gm);
        end
    endtask

    task drain();
        stall <= 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (exp_q.size() != 0)
        begin
            err_total++;
            print_verdict();
        end
    endtask

    // random output back-pressure
    always @(posedge clk)
        pix_out_ready <= !stall && ((rnd() & 32'h3) != 32'h0);

    // scoreboard on the output stream
    always @(posedge clk)
        if (reset_n && pix_out_valid && pix_out_ready)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk({16'h0, pix_out_data}, {16'h0, exp_q.pop_front()});
        end

    // run limit
    initial
    begin
        #2500000;
        err_total++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        {reset_n, psel, penable, pwrite, stall, osel} = 6'h0;
        {paddr, pwdata, err_total, total_checks} = '0;
        seed = 32'h09cf1f48;
        msel = 2'd1;
        foff = 16'h0;
        fgain = 16'h4000;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdc(10'h03e, 8'h00, 1'b0);
        rdc(10'h03f, 8'h00, 1'b0);
        rdc(10'h040, 8'h40, 1'b0);
        rdc(10'h041, 8'h00, 1'b0);
        rdc(10'h042, 8'h01, 1'b0);
        rdc(10'h043, 8'h02, 1'b0);
        apb(1'b1, 10'h042, 8'hff);
        rdc(10'h042, 8'h07, 1'b0);
        apb(1'b1, 10'h3ff, 8'h55);
        rdc(10'h3ff, 8'h00, 1'b1);
        // back to fixed sources so the stream matches the model's settings
        apb(1'b1, 10'h042, 8'h01);
        $display("register test done");
        send(6, 4'h3);
        drain();
        for (int m = 0; m < 9; m++)
        begin
            r = rnd();
            {osel, msel} = (m == 8) ? 3'h1 : m[2:0];
            foff = {4'h0, r[11:0]};
            fgain = r[31:16];
            apb(1'b1, 10'h03e, foff[15:8]);
            apb(1'b1, 10'h03f, foff[7:0]);
            apb(1'b1, 10'h040, fgain[15:8]);
            apb(1'b1, 10'h041, fgain[7:0]);
            apb(1'b1, 10'h042, {5'h0, osel, msel});
            send(8, m[0] ? 4'h0 : 4'h3);
            if (m < 8)
                drain();
        end
        $display("mode test done");
        stall <= 1'b1;
        send(7, 4'h0);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pix_in_ready && n < 100);
        if (pix_in_ready)
        begin
            err_total++;
            print_verdict();
        end
        rdc(10'h043, 8'h25, 1'b0);
        drain();
        $display("fifo test done");
        print_verdict();
    end
endmodule
`default_nettype wire
